/* logic/bsc_exec.sv */
// Purpose: execute stage for skip-if-set, call, clear-file and clear-accumulator
// Assumes: file_rd_data is the byte at insn[4:0], valid in the cycle insn_valid is high
// Notes:   other opcodes are ignored here; the surrounding core executes them
// Notes on behaviour
// RL1: opcode 0111 tests bit b of file f; skip next instruction when it is one.
// RL2: taken skip discards prefetched word, runs a no-op: two cycles, else one.
// RL3: call opcode 1001 pushes program counter plus one onto the return stack.
// RL4: call loads pc[7:0]=k, pc[10:9]=status[6:5], pc[8]=0.
// RL5: call takes two cycles and changes no status flag.
// RL6: clear-file zeroes file f, clear-accumulator zeroes accumulator; both set zero flag.
`timescale 1ns/1ps
module bsc_exec
  import bsc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              insn_valid,
  input  wire logic [INSN_W-1:0] insn,
  input  wire logic [PC_W-1:0]   pc,
  input  wire logic [DATA_W-1:0] file_rd_data,
  input  wire logic [DATA_W-1:0] status,
  output bsc_file_wr_t           file_wr,
  output bsc_push_t              stack_push,
  output logic                   pc_load,
  output logic [PC_W-1:0]        pc_target,
  output logic                   acc_clear,
  output logic                   zero_set,
  output logic                   discard,
  output logic                   busy
);

  // sequencer state
  bsc_state_t                     state_r;
  bsc_state_t                     state_nxt;

  // registered outputs and their next values
  bsc_file_wr_t                   file_wr_r;
  bsc_file_wr_t                   file_wr_nxt;
  bsc_push_t                      push_r;
  bsc_push_t                      push_nxt;
  logic                           pc_load_r;
  logic                           pc_load_nxt;
  logic [PC_W-1:0]                pc_target_r;
  logic [PC_W-1:0]                pc_target_nxt;
  logic                           acc_clear_r;
  logic                           acc_clear_nxt;
  logic                           zero_set_r;
  logic                           zero_set_nxt;
  logic                           discard_r;
  logic                           discard_nxt;
  logic                           busy_r;
  logic                           busy_nxt;

  // upper opcode nibble, shared by the skip and call decodes
  function automatic logic [OP_HI-OP_LO:0] op_nibble(
    input logic [INSN_W-1:0] word
  );
    return word[OP_HI:OP_LO];
  endfunction

  // seven-bit prefix that marks the clear-file class
  function automatic logic [OP_HI-CLEAR_FILE_REG_OP_LO:0] clr_prefix(
    input logic [INSN_W-1:0] word
  );
    return word[OP_HI:CLEAR_FILE_REG_OP_LO];
  endfunction

  // raw opcode class matches, before the flush gate
  wire                            flushing;
  wire                            live;
  wire                            op_skip;
  wire                            op_call;
  wire                            op_clear_file_reg_op;
  wire                            op_clear_accumulator_op;

  // an instruction arriving during the flush cycle is the discarded prefetch
  assign flushing = (state_r == BSC_FLUSH);
  assign live     = insn_valid && !flushing;
  assign op_skip  = (op_nibble(insn) == OPC_SKIP_SET);                   // [RL1]
  assign op_call  = (op_nibble(insn) == OPC_CALL);                       // [RL3]
  assign op_clear_file_reg_op  = (clr_prefix(insn) == OPC_CLR_FILE);                  // [RL6]
  assign op_clear_accumulator_op  = (insn == OPC_CLR_ACC);                               // [RL6]

  // accepted instructions
  wire                            is_skip;
  wire                            is_call;
  wire                            is_clear_file_reg_op;
  wire                            is_clear_accumulator_op;

  assign is_skip = live && op_skip;
  assign is_call = live && op_call;
  assign is_clear_file_reg_op = live && op_clear_file_reg_op;
  assign is_clear_accumulator_op = live && op_clear_accumulator_op;

  // operand fields
  wire [BIT_HI-BIT_LO:0]          bsel;
  wire [FADR_W-1:0]               fsel;
  wire [IMM_HI:0]                 imm;
  wire [STAT_PG_HI-STAT_PG_LO:0]  page;

  assign bsel = insn[BIT_HI:BIT_LO];
  assign fsel = insn[FADR_HI:0];
  assign imm  = insn[IMM_HI:0];
  assign page = status[STAT_PG_HI:STAT_PG_LO];

  // skip and call consequences
  wire                            bit_is_set;
  wire                            skip_take;
  wire                            flush_req;
  wire [PC_W-1:0]                 call_tgt;
  wire [PC_W-1:0]                 ret_addr;

  assign bit_is_set = file_rd_data[bsel];                                // [RL1]
  assign skip_take  = is_skip && bit_is_set;                             // [RL1]
  // both taken skip and call spend one extra cycle flushing the prefetch
  assign flush_req  = skip_take || is_call;                              // [RL2] [RL5]
  // page bits fill the top, bit 8 is forced low
  assign call_tgt   = {page, 1'b0, imm};                                 // [RL4]
  // wraps at the top of program space, as the counter itself does
  assign ret_addr   = pc + PC_ONE;                                       // [RL3]

  // next values
  assign state_nxt     = flush_req ? BSC_FLUSH : BSC_EXEC;               // [RL2] [RL5]
  assign busy_nxt      = flush_req;                                      // [RL2] [RL5]
  assign file_wr_nxt   = '{en: is_clear_file_reg_op, addr: fsel, data: DATA_ZERO};    // [RL6]
  assign push_nxt      = '{en: is_call, addr: ret_addr};                 // [RL3]
  assign pc_load_nxt   = is_call;                                        // [RL4]
  // target is refreshed every cycle; it only matters alongside pc_load
  assign pc_target_nxt = call_tgt;                                       // [RL4]
  assign acc_clear_nxt = is_clear_accumulator_op;                                        // [RL6]
  // a call leaves the flags alone
  assign zero_set_nxt  = is_clear_file_reg_op || is_clear_accumulator_op;                             // [RL6] [RL5]
  assign discard_nxt   = flush_req;                                      // [RL2]

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= BSC_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // busy has its own flop so the port is not a decode of the state
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      file_wr_r <= '0;
    end else begin
      file_wr_r <= file_wr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      push_r <= '0;
    end else begin
      push_r <= push_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_load_r <= 1'b0;
    end else begin
      pc_load_r <= pc_load_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_target_r <= PC_RESET;
    end else begin
      pc_target_r <= pc_target_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_clear_r <= 1'b0;
    end else begin
      acc_clear_r <= acc_clear_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      zero_set_r <= 1'b0;
    end else begin
      zero_set_r <= zero_set_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      discard_r <= 1'b0;
    end else begin
      discard_r <= discard_nxt;
    end
  end

  // every port comes straight from a flop
  assign file_wr    = file_wr_r;
  assign stack_push = push_r;
  assign pc_load    = pc_load_r;
  assign pc_target  = pc_target_r;
  assign acc_clear  = acc_clear_r;
  assign zero_set   = zero_set_r;
  assign discard    = discard_r;
  assign busy       = busy_r;

endmodule

/* pkg/bsc_pkg.sv */
// Purpose: shared constants and carriers for the bit-skip/call/clear execute block
// Assumes: 12-bit instruction words, 8-bit data path, 11-bit program counter
// Notes:   opcode patterns and field positions for bsc_exec live here only
package bsc_pkg;

  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int PC_W   = 11;
  localparam int FADR_W = 5;

  // opcode classes
  localparam logic [3:0]  OPC_SKIP_SET  = 4'h7;
  localparam logic [3:0]  OPC_CALL      = 4'h9;
  localparam logic [6:0]  OPC_CLR_FILE  = 7'h03;
  localparam logic [11:0] OPC_CLR_ACC   = 12'h040;

  // field positions
  localparam int OP_HI    = 11;
  localparam int OP_LO    = 8;
  localparam int CLEAR_FILE_REG_OP_LO  = 5;
  localparam int BIT_HI   = 7;
  localparam int BIT_LO   = 5;
  localparam int FADR_HI  = 4;
  localparam int IMM_HI   = 7;
  localparam int STAT_PG_HI = 6;
  localparam int STAT_PG_LO = 5;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [PC_W-1:0]   PC_ONE    = 11'h001;
  localparam logic [PC_W-1:0]   PC_RESET  = 11'h000;

  // one-cycle write request to the register file
  typedef struct packed {
    logic              en;
    logic [FADR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bsc_file_wr_t;

  // one-cycle push request to the return stack
  typedef struct packed {
    logic            en;
    logic [PC_W-1:0] addr;
  } bsc_push_t;

  typedef enum logic [1:0] {
    BSC_EXEC  = 2'b00,
    BSC_FLUSH = 2'b01
  } bsc_state_t;

endpackage

/* tb/bsc_exec_props.sv */
// Purpose: port checks  Assumes: one-cycle answers  Notes: bound by name
`timescale 1ns/1ps
module bsc_exec_props import bsc_pkg::*; (
  input logic clk, srst, insn_valid, busy, discard, zero_set, acc_clear, pc_load,
  input logic [INSN_W-1:0] insn, input logic [PC_W-1:0] pc, pc_target,
  input logic [DATA_W-1:0] file_rd_data, status,
  input bsc_file_wr_t file_wr, input bsc_push_t stack_push);
  default clocking @(posedge clk); endclocking default disable iff (srst);
  wire sk = insn_valid && !busy && insn[11:8] == 4'h7;
  wire cl = insn_valid && !busy && insn[11:8] == 4'h9;
  skip_set_a: assert property (sk && file_rd_data[insn[7:5]] |=> discard && busy)
    else $error("skip");
  skip_clr_a: assert property (sk && !file_rd_data[insn[7:5]] |=> !discard && !busy)
    else $error("noskip");
  skip_two_a: assert property (sk && file_rd_data[insn[7:5]] |=> busy ##1 !busy && !discard)
    else $error("skip length");
  push_addr_a: assert property (cl |=> stack_push == {1'b1, $past(pc) + 11'h001})
    else $error("push");
  call_pc_a: assert property (cl |=> pc_load && pc_target ==
    {$past(status[6:5]), 1'b0, $past(insn[7:0])}) else $error("target");
  call_two_a: assert property (cl |=> busy && !zero_set ##1 !busy) else $error("call");
  clr_file_a: assert property (insn_valid && !busy && insn[11:5] == 7'h03 |=> zero_set &&
    file_wr == {1'b1, $past(insn[4:0]), 8'h00}) else $error("clear");
  clr_acc_a: assert property (insn_valid && !busy && insn == 12'h040 |=> acc_clear && zero_set)
    else $error("clear acc");
endmodule
bind bsc_exec bsc_exec_props u_props (.*);

/* tb/tb_bsc_exec.sv */
// Purpose: random pulse run  Assumes: negedge drive  Notes: props check values
`timescale 1ns/1ps
module tb_bsc_exec import bsc_pkg::*;;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              insn_valid = 1'b0;
  logic [INSN_W-1:0] insn = 12'h000;
  logic [PC_W-1:0]   pc = 11'h000;
  logic [DATA_W-1:0] file_rd_data = 8'h00;
  logic [DATA_W-1:0] status = 8'h00;
  bsc_file_wr_t      file_wr;
  bsc_push_t         stack_push;
  logic              pc_load;
  logic              acc_clear;
  logic              zero_set;
  logic              discard;
  logic              busy;
  logic [PC_W-1:0]   pc_target;
  logic [6:0]        exp_r = 7'h00;
  logic [PC_W-1:0]   exp_ret = 11'h000;
  logic [PC_W-1:0]   exp_tgt = 11'h000;
  logic [FADR_W-1:0] exp_fa = 5'h00;
  int                num_errors = 0;
  int                tests_run = 0;
  int                cyc = 0;
  int                r;
  int                seed = 32'haa03;

  bsc_exec u_dut (
    .clk          (clk),
    .srst         (srst),
    .insn_valid   (insn_valid),
    .insn         (insn),
    .pc           (pc),
    .file_rd_data (file_rd_data),
    .status       (status),
    .file_wr      (file_wr),
    .stack_push   (stack_push),
    .pc_load      (pc_load),
    .pc_target    (pc_target),
    .acc_clear    (acc_clear),
    .zero_set     (zero_set),
    .discard      (discard),
    .busy         (busy)
  );

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc >= 3000) begin
      num_errors++;
      final_report();
    end
  end

  // expected busy marks the flush, so a refused prefetch predicts nothing
  function automatic logic [6:0] model(input logic t, input logic [INSN_W-1:0] i,
                                       input logic [DATA_W-1:0] fd);
    logic s;
    logic c;
    logic f;
    logic w;
    s = t && i[11:8] == 4'h7 && fd[i[7:5]];
    c = t && i[11:8] == 4'h9;
    f = t && i[11:5] == 7'h03;
    w = t && i == 12'h040;
    return {f, c, c, w, f | w, s | c, s | c};
  endfunction

  // random word biased towards the four handled classes
  function automatic logic [INSN_W-1:0] pick_insn(input int q);
    if (q[3]) return {q[2] ? 4'h7 : 4'h9, q[15:8]};
    else if (q[2]) return {7'h03, q[12:8]};
    else if (q[1]) return 12'h040;
    else return q[15:4];
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // check the answer to the previous drive, then drive the next cycle
  task automatic step(input logic s, input logic v, input logic [INSN_W-1:0] i,
                      input logic [DATA_W-1:0] fd, input logic [DATA_W-1:0] st,
                      input logic [PC_W-1:0] p);
    @(negedge clk);
    chk("pulses", 16'({file_wr.en, stack_push.en, pc_load, acc_clear, zero_set,
                       discard, busy}), 16'(exp_r));
    if (exp_r[5]) chk("push addr", 16'(stack_push.addr), 16'(exp_ret));
    if (exp_r[4]) chk("call target", 16'(pc_target), 16'(exp_tgt));
    if (exp_r[6]) chk("clear addr", 16'(file_wr.addr), 16'(exp_fa));
    if (exp_r[6]) chk("clear data", 16'(file_wr.data), 16'h0000);
    srst = s;
    insn_valid = v;
    insn = i;
    file_rd_data = fd;
    status = st;
    pc = p;
    exp_r = s ? 7'h00 : model(v && !exp_r[0], i, fd);
    exp_ret = p + 11'h001;
    exp_tgt = {st[6:5], 1'b0, i[7:0]};
    exp_fa = i[4:0];
  endtask

  initial begin
    repeat (3) step(1'b1, 1'b0, 12'h000, 8'h00, 8'h00, 11'h000);
    step(1'b0, 1'b1, 12'h7e0, 8'h80, 8'h00, 11'h010);
    step(1'b0, 1'b1, 12'h9ff, 8'h00, 8'h60, 11'h011);
    step(1'b0, 1'b1, 12'h7e0, 8'h7f, 8'h00, 11'h012);
    step(1'b0, 1'b1, 12'h9a5, 8'h00, 8'h60, 11'h7ff);
    step(1'b0, 1'b1, 12'h07f, 8'h00, 8'h00, 11'h100);
    step(1'b0, 1'b1, 12'h060, 8'h00, 8'h00, 11'h101);
    step(1'b0, 1'b1, 12'h040, 8'h00, 8'h00, 11'h102);
    step(1'b0, 1'b0, 12'h9a5, 8'h00, 8'h40, 11'h103);
    step(1'b0, 1'b1, 12'h95a, 8'h00, 8'h20, 11'h200);
    step(1'b1, 1'b1, 12'h7e0, 8'hff, 8'h00, 11'h201);
    step(1'b0, 1'b1, 12'h040, 8'h00, 8'h00, 11'h202);
    repeat (2000) begin
      r = $random(seed);
      step(1'b0, r[4], pick_insn(r), r[23:16], r[31:24], r[15:5]);
    end
    step(1'b0, 1'b0, 12'h000, 8'h00, 8'h00, 11'h000);
    final_report();
  end
endmodule
